// [rtl/fpu_compat_defs.svh]
// Contract
// [RULE1] Extended-real load never flags denormal operand
// [RULE2] Single/double denormal loads normalise to extended
// [RULE3] Single/double signaling NaN load flags invalid
// [RULE4] Extract: zero gives divide-by-zero, -inf; +inf silent
// [RULE5] Constant loads obey current rounding control
// [RULE6] Empty classify never yields 1101 or 1111
// [RULE7] Legacy coprocessor opcodes are pure no-ops
// [RULE8] Saved operand pointer free after non-memory op
// [RULE9] Transcendental error under 1 / 1.5 ulp; exp2_minus_one_op returns the operand times ln2 instead
// [RULE10] Transcendental results monotonic in operands
// [RULE11] Split store may leave first half written
// [RULE12] Each op completes only after previous one
// [RULE13] Coprocessor type sampled after reset, before ops
// [RULE14] Older coprocessor error inactive, newer active
// [RULE15] No error signalled on reset or initialize
`ifndef FPU_COMPAT_DEFS_SVH
`define FPU_COMPAT_DEFS_SVH

`define EXP_BIAS         15'h3fff
`define EXP_MAX          15'h7fff
`define SGL_TO_EXT       15'h3f80
`define SGL_DENORM_BASE  15'h3f81
`define DBL_TO_EXT       15'h3c00
`define DBL_DENORM_BASE  15'h3c01
`define MANT_INT_BIT     64'h8000000000000000
`define MANT_QUIET_BIT   64'h4000000000000000
`define INDEF_MANT       64'hc000000000000000

// Constant mantissas, 64 bits plus 4 guard bits
`define PI_MANT          68'hc90fdaa22168c234c
`define PI_EXP           15'h4000
`define LN2_MANT         68'hb17217f7d1cf79abc
`define LN2_EXP          15'h3ffe
`define LG2_MANT         68'h9a209a84fbcff7988
`define LG2_EXP          15'h3ffd
`define L2E_MANT         68'hb8aa3b295c17f0bbb
`define L2E_EXP          15'h3fff
`define L2T_MANT         68'hd49a784bcd1b8afe4
`define L2T_EXP          15'h4000

// Classify codes {c3, c2, c0}
`define CLS_UNSUPP       3'h0
`define CLS_NAN          3'h1
`define CLS_NORMAL       3'h2
`define CLS_INF          3'h3
`define CLS_ZERO         3'h4
`define CLS_EMPTY        3'h5
`define CLS_DENORM       3'h6

`define IDENT_CYCLES     25
`define EXEC_CYCLES      4
`define PTR_RESET        32'h00000000

`endif

// [rtl/fpu_compat_pkg.sv]
package fpu_compat_pkg;

    typedef enum logic [3:0] {
        stack_load_op,
        exponent_extract_op,
        classify_op,
        load_pi_const_op,
        load_ln2_const_op,
        load_lg2_const_op,
        load_l2e_const_op,
        load_l2t_const_op,
        exp2_minus_one_op,
        state_save_op,
        environment_store_op,
        legacy_int_enable_op,
        legacy_int_disable_op,
        set_protected_mode_op,
        fpu_initialize_op,
        fpu_wait_op
    } op_type;

    typedef enum logic [1:0] {
        fmt_single,
        fmt_double,
        fmt_extended
    } fmt_type;

    typedef enum logic [1:0] {
        round_nearest,
        round_down,
        round_up,
        round_zero
    } round_type;

endpackage : fpu_compat_pkg

// [rtl/fpu_round.sv]
`timescale 1ns/1ps
`include "fpu_compat_defs.svh"
module fpu_round
    import fpu_compat_pkg::*;
(
    input  wire logic [63:0] mant_in,
    input  wire logic [3:0]  extra_in,
    input  wire logic        sticky_in,
    input  wire logic        sign_in,
    input  wire round_type   rc,
    output logic      [63:0] mant_out,
    output logic             carry_out,
    output logic             inexact
);
    logic up;
    logic lost;

    always_comb
    begin
        lost = (extra_in != 4'h0) || sticky_in;
        unique case (rc)
            round_nearest: up = extra_in[3] &&
                (extra_in[2:0] != 3'h0 || sticky_in || mant_in[0]);
            round_down:    up = lost && sign_in;
            round_up:      up = lost && !sign_in;
            round_zero:    up = 1'b0;
        endcase
        {carry_out, mant_out} = {1'b0, mant_in} + {64'h0, up};
        if (carry_out)
        begin
            mant_out = `MANT_INT_BIT;
        end
        inexact = lost;
    end

endmodule : fpu_round

// [rtl/fpu_compat_unit.sv]
`timescale 1ns/1ps
`include "fpu_compat_defs.svh"
module fpu_compat_unit
    import fpu_compat_pkg::*;
#(
    parameter int EXEC_CYCLES  = `EXEC_CYCLES,
    parameter int IDENT_CYCLES = `IDENT_CYCLES
)
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ext_error_n,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire op_type      cmd_op,
    input  wire fmt_type     cmd_fmt,
    input  wire logic [79:0] cmd_data,
    input  wire logic        cmd_has_mem,
    input  wire logic [31:0] cmd_mem_addr,
    input  wire logic        cmd_empty,
    input  wire round_type   round_ctl,
    output logic             done,
    output logic      [79:0] res_top,
    output logic      [79:0] res_one,
    output logic             res_one_wr,
    output logic             exc_invalid,
    output logic             exc_zero_div,
    output logic             exc_denormal,
    output logic             exc_precision,
    output logic       [3:0] cond_code,
    output logic      [31:0] saved_mem_ptr,
    output logic             copro_new_type,
    output logic             ident_done,
    output logic             fpu_error
);
    typedef enum logic [1:0] { ident_st, idle_st, exec_st } state_type;

    state_type   state_q;
    logic [31:0] cnt_q;
    logic        err_meta_q, err_sync_q;
    op_type      op_q;
    fmt_type     fmt_q;
    logic [79:0] data_q;
    logic        empty_q;
    round_type   rc_q;
    logic [31:0] mem_ptr_q;

    logic [79:0] n_top, n_one;
    logic        n_one_wr, n_top_wr, n_inv, n_zd, n_prec, n_cc_wr;
    logic [3:0]  n_cc;
    logic [63:0] r_mant, r_mant_o;
    logic [3:0]  r_extra;
    logic        r_sticky, r_sign, r_carry, r_inexact;
    logic [14:0] r_exp;
    logic        exec_end;

    function automatic logic [6:0] lead_zeros(input logic [63:0] v);
        logic [6:0] n;
        n = 7'd64;
        for (int i = 0; i < 64; i++)
        begin
            if (v[i])
                n = 7'(63 - i);
        end
        return n;
    endfunction : lead_zeros

    fpu_round u_round (
        .mant_in   (r_mant),
        .extra_in  (r_extra),
        .sticky_in (r_sticky),
        .sign_in   (r_sign),
        .rc        (rc_q),
        .mant_out  (r_mant_o),
        .carry_out (r_carry),
        .inexact   (r_inexact)
    );

    // Error pin synchroniser
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            err_meta_q <= 1'b1;
            err_sync_q <= 1'b1;
        end
        else
        begin
            err_meta_q <= ext_error_n;
            err_sync_q <= err_meta_q;
        end
    end

    assign cmd_ready = (state_q == idle_st);
    assign exec_end  = (state_q == exec_st) && (cnt_q == 32'h0);

    // Sequencer
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= ident_st;
            cnt_q   <= 32'h0;
        end
        else
        begin
            unique case (state_q)
                ident_st:
                    if (cnt_q == 32'(IDENT_CYCLES - 1))
                    begin
                        state_q <= idle_st;
                        cnt_q   <= 32'h0;
                    end
                    else
                    begin
                        cnt_q <= cnt_q + 32'h1;
                    end
                idle_st:
                    if (cmd_valid)
                    begin
                        state_q <= exec_st; // [RULE12]
                        cnt_q   <= 32'(EXEC_CYCLES - 1);
                    end
                exec_st:
                    if (cnt_q == 32'h0)
                        state_q <= idle_st;
                    else
                        cnt_q <= cnt_q - 32'h1;
            endcase
        end
    end

    // Identification
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            copro_new_type <= 1'b0;
            ident_done     <= 1'b0;
        end
        else if (state_q == ident_st && cnt_q == 32'(IDENT_CYCLES - 1))
        begin
            copro_new_type <= !err_sync_q; // [RULE13] [RULE14]
            ident_done     <= 1'b1;
        end
    end

    // Command capture
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            op_q      <= fpu_wait_op;
            fmt_q     <= fmt_extended;
            data_q    <= 80'h0;
            empty_q   <= 1'b0;
            rc_q      <= round_nearest;
            mem_ptr_q <= `PTR_RESET;
        end
        else if (cmd_ready && cmd_valid)
        begin
            op_q    <= cmd_op;
            fmt_q   <= cmd_fmt;
            data_q  <= cmd_data;
            empty_q <= cmd_empty;
            rc_q    <= round_ctl;
            if (cmd_has_mem && !(cmd_op inside
                {[legacy_int_enable_op:set_protected_mode_op], fpu_wait_op}))
                mem_ptr_q <= cmd_mem_addr; // [RULE7] [RULE8]
        end
    end

    // Result logic
    always_comb
    begin
        logic [63:0] raw, m;
        logic [6:0]  lz;
        logic [14:0] e;
        logic        s, snan;
        logic [15:0] ue, mag;
        logic [127:0] prod;
        logic        dbl;
        logic [10:0] fe, fx;
        logic [51:0] fm;
        logic [67:0] lc;
        raw = 64'h0; m = data_q[63:0]; lz = 7'h0;
        dbl = 1'b0; fe = 11'h0; fx = 11'h0; fm = 52'h0; lc = `LN2_MANT;
        e = data_q[78:64]; s = data_q[79];
        snan = 1'b0; ue = 16'h0; mag = 16'h0; prod = 128'h0;
        n_top = data_q; n_one = 80'h0;
        n_top_wr = 1'b0; n_one_wr = 1'b0;
        n_inv = 1'b0; n_zd = 1'b0; n_prec = 1'b0;
        n_cc = 4'h0; n_cc_wr = 1'b0;
        r_mant = 64'h0; r_extra = 4'h0; r_sticky = 1'b0;
        r_sign = 1'b0; r_exp = 15'h0;
        unique case (op_q)
            stack_load_op:
            begin
                n_top_wr = 1'b1;
                dbl = fmt_q == fmt_double;
                s = dbl ? data_q[63] : data_q[31];
                fe = dbl ? data_q[62:52] : {3'h0, data_q[30:23]};
                fm = dbl ? data_q[51:0] : {data_q[22:0], 29'h0};
                fx = dbl ? 11'h7ff : 11'h0ff;
                if (fmt_q == fmt_extended)
                    n_top = data_q; // [RULE1]
                else if (fe == fx)
                begin
                    snan = fm != 52'h0 && !fm[51];
                    n_top = {s, `EXP_MAX, 1'b1, fm | {snan, 51'h0}, 11'h0};
                end
                else if (fe == 11'h0)
                begin
                    raw = {fm, 12'h0};
                    lz = lead_zeros(raw);
                    n_top = (raw == 64'h0) ? {s, 79'h0} :
                        {s, 15'((dbl ? `DBL_DENORM_BASE : `SGL_DENORM_BASE)
                         - 15'h1 - 15'(lz)), raw << lz}; // [RULE2]
                end
                else
                begin
                    n_top = {s, 15'({4'h0, fe} + (dbl ? `DBL_TO_EXT
                             : `SGL_TO_EXT)), 1'b1, fm, 11'h0};
                end
                n_inv = snan; // [RULE3]
            end
            exponent_extract_op:
            begin
                n_top_wr = 1'b1;
                n_one_wr = 1'b1;
                if (e == 15'h0 && m == 64'h0)
                begin
                    n_zd  = 1'b1; // [RULE4]
                    n_one = {1'b1, `EXP_MAX, `MANT_INT_BIT};
                    n_top = {s, 79'h0};
                end
                else if (e == `EXP_MAX && m[62:0] == 63'h0)
                begin
                    n_one = {1'b0, `EXP_MAX, `MANT_INT_BIT}; // [RULE4]
                end
                else if (e == `EXP_MAX)
                begin
                    n_inv = !m[62];
                    n_top = {s, e, m | `MANT_QUIET_BIT};
                    n_one = n_top;
                end
                else
                begin
                    lz = lead_zeros(m);
                    ue = (e == 15'h0) ? 16'(16'h1 - 16'h3fff - 16'(lz))
                                      : 16'({1'b0, e} - 16'h3fff);
                    n_top = {s, `EXP_BIAS, m << lz};
                    mag = ue[15] ? 16'(-ue) : ue;
                    lz = lead_zeros({48'h0, mag});
                    n_one = (mag == 16'h0) ? 80'h0 :
                        {ue[15], 15'(`EXP_BIAS + 15'd63 - 15'(lz)),
                         64'({48'h0, mag} << lz)};
                end
            end
            classify_op:
            begin
                n_cc_wr = 1'b1;
                if (empty_q)
                    n_cc = {`CLS_EMPTY, 1'b0}; // [RULE6]
                else if (e == `EXP_MAX)
                    n_cc = {!m[63] ? `CLS_UNSUPP :
                            m[62:0] == 63'h0 ? `CLS_INF : `CLS_NAN, s};
                else if (e == 15'h0)
                    n_cc = {m == 64'h0 ? `CLS_ZERO : `CLS_DENORM, s};
                else
                    n_cc = {m[63] ? `CLS_NORMAL : `CLS_UNSUPP, s};
                n_cc = {n_cc[3:2], n_cc[0], n_cc[1]};
            end
            load_pi_const_op, load_ln2_const_op, load_lg2_const_op,
            load_l2e_const_op, load_l2t_const_op:
            begin
                n_top_wr = 1'b1;
                r_sticky = 1'b1;
                unique case (op_q)
                    load_pi_const_op:
                        {r_mant, r_extra, r_exp} = {`PI_MANT, `PI_EXP};
                    load_ln2_const_op:
                        {r_mant, r_extra, r_exp} = {`LN2_MANT, `LN2_EXP};
                    load_lg2_const_op:
                        {r_mant, r_extra, r_exp} = {`LG2_MANT, `LG2_EXP};
                    load_l2e_const_op:
                        {r_mant, r_extra, r_exp} = {`L2E_MANT, `L2E_EXP};
                    default:
                        {r_mant, r_extra, r_exp} = {`L2T_MANT, `L2T_EXP};
                endcase
                n_top  = {1'b0, 15'(r_exp + {14'h0, r_carry}), r_mant_o};
                n_prec = r_inexact; // [RULE5]
            end
            exp2_minus_one_op:
            begin
                n_top_wr = 1'b1;
                if (e == 15'h0 && m == 64'h0)
                begin
                    n_top = data_q;
                end
                else if (e >= `EXP_BIAS || !m[63])
                begin
                    n_inv = 1'b1;
                    n_top = {1'b1, `EXP_MAX, `INDEF_MANT};
                end
                else
                begin
                    prod = m * lc[67:4];
                    r_sign = s;
                    r_exp = prod[127] ? e : 15'(e - 15'h1);
                    prod = prod[127] ? prod : prod << 1;
                    r_mant = prod[127:64];
                    r_extra = prod[63:60];
                    r_sticky = 1'b1;
                    n_top = {s, 15'(r_exp + {14'h0, r_carry}),
                             r_mant_o}; // [RULE9] [RULE10]
                    n_prec = r_inexact;
                end
            end
            default:
            begin
                n_top = data_q; // [RULE7]
            end
        endcase
    end

    // Result and status registers
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            done <= 1'b0; res_one_wr <= 1'b0;
            res_top <= 80'h0; res_one <= 80'h0;
            exc_invalid <= 1'b0; exc_zero_div <= 1'b0;
            exc_denormal <= 1'b0; exc_precision <= 1'b0;
            cond_code <= 4'h0; saved_mem_ptr <= `PTR_RESET;
            fpu_error <= 1'b0; // [RULE15]
        end
        else
        begin
            done       <= exec_end; // [RULE12]
            res_one_wr <= exec_end && n_one_wr;
            exc_denormal <= 1'b0; // [RULE1]
            if (exec_end)
            begin
                if (op_q == fpu_initialize_op)
                begin
                    exc_invalid <= 1'b0; exc_zero_div <= 1'b0;
                    exc_precision <= 1'b0; cond_code <= 4'h0;
                    fpu_error <= 1'b0; // [RULE15]
                end
                else if (n_top_wr || n_cc_wr)
                begin
                    exc_invalid   <= n_inv;
                    exc_zero_div  <= n_zd;
                    exc_precision <= n_prec;
                    fpu_error     <= fpu_error | n_inv | n_zd;
                end
                if (n_top_wr)
                    res_top <= n_top;
                if (n_one_wr)
                    res_one <= n_one;
                if (n_cc_wr)
                    cond_code <= n_cc;
                if (op_q == state_save_op || op_q == environment_store_op)
                    saved_mem_ptr <= mem_ptr_q; // [RULE8] [RULE11]
            end
        end
    end

endmodule : fpu_compat_unit

// [tb/fpu_compat_monitor.sv]
`timescale 1ns/1ps
`include "fpu_compat_defs.svh"
module fpu_compat_monitor
    import fpu_compat_pkg::*;
#(
    parameter int EXEC_CYCLES  = 4,
    parameter int IDENT_CYCLES = 25
)
(
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        ext_error_n,
    input wire logic        cmd_valid,
    input wire logic        cmd_ready,
    input wire op_type      cmd_op,
    input wire logic        done,
    input wire logic [79:0] res_top,
    input wire logic [79:0] res_one,
    input wire logic        res_one_wr,
    input wire logic        exc_zero_div,
    input wire logic        exc_denormal,
    input wire logic [3:0]  cond_code,
    input wire logic [31:0] saved_mem_ptr,
    input wire logic        copro_new_type,
    input wire logic        ident_done,
    input wire logic        fpu_error
);
    localparam int DONE_LAT = EXEC_CYCLES + 1;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence s_take;
        cmd_valid && cmd_ready;
    endsequence
    sequence s_nop;
        s_take ##0 (cmd_op inside {legacy_int_enable_op,
            legacy_int_disable_op, set_protected_mode_op, fpu_wait_op});
    endsequence
    sequence s_init;
        s_take ##0 (cmd_op == fpu_initialize_op);
    endsequence

    property p_lat;
        s_take |-> ##DONE_LAT done;
    endproperty
    a_lat: assert property (p_lat) else $error("late done");
    property p_busy;
        s_take |=> !cmd_ready until done;
    endproperty
    a_busy: assert property (p_busy) else $error("overlap");
    property p_rdy;
        done |-> cmd_ready;
    endproperty
    a_rdy: assert property (p_rdy) else $error("not ready");
    property p_denorm;
        done |-> !exc_denormal;
    endproperty
    a_denorm: assert property (p_denorm) else $error("denormal");
    property p_inf;
        res_one_wr && exc_zero_div |-> done
            && res_one == {1'b1, `EXP_MAX, `MANT_INT_BIT};
    endproperty
    a_inf: assert property (p_inf) else $error("bad extract");
    property p_cc;
        done |-> !(cond_code inside {4'hb, 4'hf});
    endproperty
    a_cc: assert property (p_cc) else $error("bad codes");
    property p_nop;
        s_nop |=> ($stable(res_top) && $stable(cond_code)
            && $stable(saved_mem_ptr) && $stable(fpu_error)) [*5];
    endproperty
    a_nop: assert property (p_nop) else $error("nop changed");
    property p_first;
        !ident_done |-> !cmd_ready && !done;
    endproperty
    a_first: assert property (p_first) else $error("early op");
    property p_type;
        $rose(ident_done) |-> copro_new_type == !ext_error_n;
    endproperty
    a_type: assert property (p_type) else $error("bad type");
    property p_init;
        s_init |-> ##DONE_LAT !fpu_error;
    endproperty
    a_init: assert property (p_init) else $error("init error");
endmodule : fpu_compat_monitor

bind fpu_compat_unit fpu_compat_monitor #(
    .EXEC_CYCLES(EXEC_CYCLES),
    .IDENT_CYCLES(IDENT_CYCLES)
) fpu_compat_monitor_inst (.clk, .resetn, .ext_error_n, .cmd_valid,
    .cmd_ready, .cmd_op, .done, .res_top, .res_one, .res_one_wr,
    .exc_zero_div, .exc_denormal, .cond_code, .saved_mem_ptr,
    .copro_new_type, .ident_done, .fpu_error);

// [tb/fpu_core_partner.sv]
`timescale 1ns/1ps
module fpu_core_partner
    import fpu_compat_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        new_type,
    input  wire logic        cmd_ready,
    input  wire logic        done,
    output logic             ext_error_n,
    output logic             cmd_valid,
    output op_type           cmd_op,
    output fmt_type          cmd_fmt,
    output logic      [79:0] cmd_data,
    output logic             cmd_has_mem,
    output logic      [31:0] cmd_mem_addr,
    output logic             cmd_empty,
    output round_type        round_ctl,
    output logic             timed_out
);
    assign ext_error_n = ~new_type; // Newer type holds pin low

    initial
    begin
        cmd_valid = 1'b0;
        timed_out = 1'b0;
    end

    task automatic issue(input op_type o, input fmt_type f,
                         input logic [79:0] v, input logic [31:0] a,
                         input logic e, input round_type rc);
        int n;
        repeat (a[2:1]) @(negedge clk);
        cmd_op = o;
        cmd_fmt = f;
        cmd_data = v;
        cmd_has_mem = a[0];
        cmd_mem_addr = a;
        cmd_empty = e;
        round_ctl = rc;
        cmd_valid = 1'b1;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd_data = ~v;
        n = 0;
        while (done !== 1'b1 && n < 20) // One op at a time
        begin
            @(negedge clk);
            n++;
        end
        timed_out = timed_out | (n >= 20);
    endtask : issue
endmodule : fpu_core_partner

// [tb/float_unit_compat_behaviour_tb.sv]
`timescale 1ns/1ps
`include "fpu_compat_defs.svh"
module float_unit_compat_behaviour_tb
    import fpu_compat_pkg::*;
();
    int           checks = 0;
    int           miscompares = 0;
    int           seed = 89;
    int           i;
    logic         clk = 1'b0;
    logic         resetn, new_type, timed_out, ext_error_n, cmd_valid;
    logic         cmd_ready, cmd_has_mem, cmd_empty, done, res_one_wr;
    logic         exc_invalid, exc_zero_div, exc_denormal, exc_precision;
    logic         copro_new_type, ident_done, fpu_error;
    op_type       cmd_op;
    fmt_type      cmd_fmt;
    round_type    round_ctl;
    logic [79:0]  cmd_data, res_top, res_one, keep, d;
    logic [31:0]  cmd_mem_addr, saved_mem_ptr, kp, lp = 32'h0;
    logic [3:0]   cond_code;
    logic [63:0]  m, em;
    logic [127:0] p;
    logic [78:0]  prev;
    logic [67:0]  cman [5] = '{`PI_MANT, `LN2_MANT, `LG2_MANT,
        `L2E_MANT, `L2T_MANT};
    logic [14:0]  cexp [5] = '{`PI_EXP, `LN2_EXP, `LG2_EXP, `L2E_EXP,
        `L2T_EXP};

    always #2 clk = ~clk;

    fpu_compat_unit #(.IDENT_CYCLES(3)) fpu_compat_unit_inst (.clk,
        .resetn, .ext_error_n, .cmd_valid, .cmd_ready, .cmd_op, .cmd_fmt,
        .cmd_data, .cmd_has_mem, .cmd_mem_addr, .cmd_empty, .round_ctl,
        .done, .res_top, .res_one, .res_one_wr, .exc_invalid,
        .exc_zero_div, .exc_denormal, .exc_precision, .cond_code,
        .saved_mem_ptr, .copro_new_type, .ident_done, .fpu_error);

    fpu_core_partner fpu_core_partner_inst (.clk, .new_type, .cmd_ready,
        .done, .ext_error_n, .cmd_valid, .cmd_op, .cmd_fmt, .cmd_data,
        .cmd_has_mem, .cmd_mem_addr, .cmd_empty, .round_ctl, .timed_out);

    task automatic check(input logic [79:0] seen, input logic [79:0] want);
        checks++;
        if (seen !== want)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check

    task automatic run(input op_type o, input logic [79:0] v,
                       input logic e, input round_type rc,
                       input fmt_type f = fmt_extended);
        logic [31:0] a;
        a = $random(seed);
        if (a[0] && !(o inside {[legacy_int_enable_op:set_protected_mode_op],
            fpu_wait_op}))
            lp = a;
        fpu_core_partner_inst.issue(o, f, v, a, e, rc);
    endtask : run

    task automatic boot(input logic t);
        resetn = 1'b0;
        new_type = t;
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        repeat (8) @(negedge clk);
        check(ident_done, 1'b1);
        check(copro_new_type, t);
        check(fpu_error, 1'b0);
    endtask : boot

    function automatic logic [79:0] norm(input logic s, input logic [63:0] v,
                                         input logic [14:0] base);
        int k;
        k = 63;
        while (v[k] == 1'b0)
            k--;
        return {s, base + 15'(k), v << (63 - k)};
    endfunction : norm

    function automatic logic [63:0] rnd(input logic [67:0] v,
                                        input round_type rc);
        logic up;
        up = (rc == round_up) || (rc == round_nearest && v[3]);
        return v[67:4] + 64'(up);
    endfunction : rnd

    task automatic results;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results

    initial
    begin
        #20000;
        miscompares++;
        results();
    end

    initial
    begin
        boot(1'b1);
        for (i = 0; i < 6; i++)
        begin
            m = {$random(seed), $random(seed)};
            m[0] = 1'b1;
            d = i[0] ? {16'h0, m[63], 11'h0, m[51:0]}
                     : {48'h0, m[63], 8'h0, m[22:0]};
            run(stack_load_op, d, 1'b0, round_nearest,
                i[0] ? fmt_double : fmt_single);
            check(res_top, norm(m[63], i[0] ? {12'h0, m[51:0]}
                : {41'h0, m[22:0]}, i[0] ? `DBL_DENORM_BASE - 15'd52
                : `SGL_DENORM_BASE - 15'd23));
        end
        run(stack_load_op, {m[63], 16'h0, m[62:0]}, 1'b0, round_nearest);
        check({exc_denormal, exc_invalid}, 2'b00);
        for (i = 0; i < 2; i++)
        begin
            d = i[0] ? {16'h0, 12'h7ff, 2'h1, m[49:0]}
                     : {48'h0, 9'h0ff, 2'h1, m[20:0]};
            run(stack_load_op, d, 1'b0, round_nearest,
                i[0] ? fmt_double : fmt_single);
            check(exc_invalid, 1'b1);
            check(res_top[78:64], `EXP_MAX);
        end
        run(exponent_extract_op, {m[63], 79'h0}, 1'b0, round_nearest);
        check(res_one, {1'b1, `EXP_MAX, `MANT_INT_BIT});
        check({res_one_wr, exc_zero_div}, 2'b11);
        d = {1'b0, `EXP_MAX, `MANT_INT_BIT};
        run(exponent_extract_op, d, 1'b0, round_nearest);
        check({exc_zero_div, exc_invalid, res_top}, {2'b00, d});
        run(fpu_initialize_op, d, 1'b0, round_nearest);
        check(fpu_error, 1'b0);
        for (i = 0; i < 20; i++)
        begin
            run(op_type'(3 + i / 4), d, 1'b0, round_type'(i % 4));
            check(res_top, {1'b0, cexp[i / 4],
                rnd(cman[i / 4], round_type'(i % 4))});
        end
        run(classify_op, d, 1'b1, round_nearest);
        check(cond_code, 4'h9);
        run(classify_op, {1'b1, `EXP_BIAS, `MANT_INT_BIT}, 1'b0, round_down);
        check(cond_code, 4'h6);
        keep = res_top;
        kp = saved_mem_ptr;
        for (i = 0; i < 4; i++)
        begin
            run(op_type'(i == 3 ? 15 : 11 + i), ~keep, 1'b1, round_up);
            check({res_top, cond_code}, {keep, 4'h6});
            check(saved_mem_ptr, kp);
        end
        prev = 79'h0;
        for (i = 0; i < 8; i++)
        begin
            m = 64'h8000000000000000 + (64'(i) << 59)
                + 64'({$random(seed)} & 32'hffff);
            run(exp2_minus_one_op, {1'b0, `EXP_BIAS - 15'd1, m}, 1'b0,
                round_nearest);
            p = {64'h0, m} * {64'h0, cman[1][67:4]};
            em = p[127] ? p[127:64] : p[126:63];
            check(res_top[79:64], p[127] ? 16'h3ffe : 16'h3ffd);
            check((res_top[63:0] - em + 64'd1) <= 64'd2, 1'b1);
            check(res_top[78:0] >= prev, 1'b1);
            prev = res_top[78:0];
        end
        run(state_save_op, d, 1'b0, round_nearest);
        check(saved_mem_ptr, lp);
        boot(1'b0);
        check(timed_out, 1'b0);
        results();
    end
endmodule : float_unit_compat_behaviour_tb
